// ==== rtl/hpt_pkg.sv ====
package hpt_pkg;
	// Geometry
	localparam int          HPT_NPORT     = 6;
	localparam int          HPT_NINST     = 8;
	localparam int          HPT_AW        = 16;
	// Register offsets: per port N at N<<12 plus the low offset
	localparam logic [15:0] HPT_OFF_STAT  = 16'h0000;
	localparam logic [11:0] HPT_OFF_OPCTL = 12'h020;
	localparam logic [11:0] HPT_OFF_MPTR  = 12'h0b0;
	localparam logic [11:0] HPT_OFF_MST   = 12'h0b8;
	localparam logic [2:0]  HPT_PORT_NONE = 3'h7;
	// Field positions
	localparam int          HPT_TTE_BIT   = 2;
	localparam int          HPT_STAT_ON   = 3;
	localparam int          HPT_ST_TXEN   = 2;
	localparam int          HPT_ST_RXEN   = 1;
	localparam int          HPT_ST_LDIS   = 0;
	localparam int          HPT_RT_PTP    = 7;
	localparam int          HPT_TT_LOOK   = 10;
	localparam int          HPT_TT_OVR    = 9;
	// Port state codes {tx enable, rx enable, learning disable}
	localparam logic [2:0]  HPT_ST_DISC   = 3'h1;
	localparam logic [2:0]  HPT_ST_LEARN  = 3'h0;
	localparam logic [2:0]  HPT_ST_FWD    = 3'h6;
	localparam logic [2:0]  HPT_ST_RESET  = 3'h6;
	// Stream framing
	localparam logic [2:0]  HPT_HOLD_TAG  = 3'h6;
	localparam logic [2:0]  HPT_HOLD_FCS  = 3'h4;
	localparam logic [2:0]  HPT_TAG_SEEN  = 3'h5;
	localparam logic [1:0]  HPT_FCS_LAST  = 2'h3;
	localparam logic [31:0] HPT_CRC_INIT  = 32'hffffffff;
	localparam logic [31:0] HPT_CRC_POLY  = 32'hedb88320;

	// Port index from a register address, NONE when unmapped
	function automatic logic [2:0] hpt_port_dec(input logic [15:0] a);
		if (a[15:12] >= 4'h1 && a[15:12] <= 4'h6)
			return a[14:12] - 3'h1;
		return HPT_PORT_NONE;
	endfunction : hpt_port_dec

	// FCS byte in wire order, lowest byte first
	function automatic logic [7:0] hpt_byte_sel(input logic [31:0] w,
		input logic [1:0] i);
		case (i)
			2'h0:    return w[7:0];
			2'h1:    return w[15:8];
			2'h2:    return w[23:16];
			default: return w[31:24];
		endcase
	endfunction : hpt_byte_sel

	// Only a discarding port without override is kept from the host
	function automatic logic hpt_host_ok(input logic [2:0] st,
		input logic ovr);
		return (st != HPT_ST_DISC) || ovr;
	endfunction : hpt_host_ok
endpackage : hpt_pkg

// ==== rtl/hpt_crc_if.sv ====
`timescale 1ns/1ps
interface hpt_crc_if;
	logic        ce;
	logic        clr;
	logic        en;
	logic [7:0]  dat;
	logic [31:0] fcs;
	modport calc (input ce, input clr, input en, input dat, output fcs);
	modport user (output ce, output clr, output en, output dat, input fcs);
endinterface : hpt_crc_if

// ==== rtl/hpt_crc.sv ====
`timescale 1ns/1ps
module hpt_crc (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Byte feed and result
	hpt_crc_if.calc  bus
);
	import hpt_pkg::*;

	logic [31:0] crc_reg;
	logic [31:0] crc_next;

	// Reflected CRC-32, one byte per enabled cycle
	always_comb begin
		crc_next = crc_reg;
		if (bus.clr) begin
			crc_next = HPT_CRC_INIT;
		end else if (bus.en) begin
			crc_next = crc_reg ^ {24'h000000, bus.dat};
			for (int b = 0; b < 8; b++) begin
				crc_next = crc_next[0] ?
					((crc_next >> 1) ^ HPT_CRC_POLY) : (crc_next >> 1);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset)
			crc_reg <= HPT_CRC_INIT;
		else if (bus.ce)
			crc_reg <= crc_next;
	end

	// Sent value is the complement, low byte goes first on the wire
	assign bus.fcs = ~crc_reg;

	chk_crc_clear_start: assert property (@(posedge i_clk) disable iff (i_reset)
		(bus.ce && bus.clr) |=> (bus.fcs == ~HPT_CRC_INIT))
		else $error("checksum did not restart after clear");
endmodule : hpt_crc

// ==== rtl/hpt_stp.sv ====
`timescale 1ns/1ps
module hpt_stp (
	// Clock, reset, enable
	input  wire logic                   i_clk,
	input  wire logic                   i_reset,
	input  wire logic                   i_ce,
	// Write port
	input  wire logic                   i_wr,
	input  wire logic [2:0]             i_wr_port,
	input  wire logic [2:0]             i_wr_inst,
	input  wire logic [2:0]             i_wr_state,
	// Read port A (ingress check) and B (register read)
	input  wire logic [2:0]             i_ra_port,
	input  wire logic [2:0]             i_ra_inst,
	output logic [2:0]                  o_ra_state,
	input  wire logic [2:0]             i_rb_port,
	input  wire logic [2:0]             i_rb_inst,
	output logic [2:0]                  o_rb_state,
	// Transmit enables of all ports for one instance
	input  wire logic [2:0]             i_vec_inst,
	output logic [hpt_pkg::HPT_NPORT-1:0] o_txen
);
	import hpt_pkg::*;

	logic [2:0] st_reg  [HPT_NPORT][HPT_NINST];
	logic [2:0] st_next [HPT_NPORT][HPT_NINST];

	// One state per port and per tree instance
	always_comb begin
		st_next = st_reg;
		if (i_wr && i_wr_port < 3'(HPT_NPORT))
			st_next[i_wr_port][i_wr_inst] = i_wr_state;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset)
			st_reg <= '{default: HPT_ST_RESET};
		else if (i_ce)
			st_reg <= st_next;
	end

	// Out-of-range ports read as discarding at port A, so only override frames pass, and as 0 at port B
	assign o_ra_state = (i_ra_port < 3'(HPT_NPORT)) ?
		st_reg[i_ra_port][i_ra_inst] : HPT_ST_DISC;
	assign o_rb_state = (i_rb_port < 3'(HPT_NPORT)) ?
		st_reg[i_rb_port][i_rb_inst] : 3'h0;

	// Transmit enable per port gates directed egress
	for (genvar p = 0; p < HPT_NPORT; p++) begin : g_txen
		assign o_txen[p] = st_reg[p][i_vec_inst][HPT_ST_TXEN];
	end

	chk_inst_store: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_ce && i_wr && i_wr_port < 3'(HPT_NPORT)) |=>
		st_reg[$past(i_wr_port)][$past(i_wr_inst)] == $past(i_wr_state))
		else $error("tree instance state not stored");
endmodule : hpt_stp

// ==== rtl/hpt_top.sv ====
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Learning port: enables clear, learning on; only host traffic passes.
// - Forwarding port: both enables set, learning on, traffic normal.
// - Tables carry 3-bit tree index; each port keeps eight states.
// - Tag sits after payload, right before the 4-byte FCS.
// - Frame to host gets exactly one tag byte naming ingress port.
// - Tag bits 2:0 give zero-based ingress port number.
// - Tag bit 7 marks PTP with timestamp; bits 6:3 reserved zero.
// - Two-byte host tag is stripped before any egress.
// - Tag bit 10 set: normal lookup, bits 9:0 ignored.
// - Bit 10 clear: bits 5:0 pick ports one to six.
// - Bit 9 sends on chosen ports despite cleared transmit enable.
// - Bits 8:7 pick egress queue; bits 15:11 reserved.
// - Tagging off after reset; per-port enable bit makes host port.
// - Tag insertion and removal happen only on the host port.
// - Discarding port: enables clear, no learning, override to host only.
module hpt_top (
	// Clock, reset, enable
	input  wire logic                    i_clk,
	input  wire logic                    i_reset,
	input  wire logic                    i_ce,
	// Register port
	input  wire logic [hpt_pkg::HPT_AW-1:0] i_addr,
	input  wire logic [31:0]             i_wdata,
	input  wire logic                    i_wr,
	input  wire logic                    i_rd,
	output logic [31:0]                  o_rdata,
	// Fabric to host port, frame without FCS
	input  wire logic                    i_th_valid,
	input  wire logic [7:0]              i_th_data,
	input  wire logic                    i_th_last,
	input  wire logic [2:0]              i_th_src,
	input  wire logic [2:0]              i_th_inst,
	input  wire logic                    i_th_ptp,
	input  wire logic                    i_th_ovr,
	output logic                         o_th_ready,
	output logic                         o_th_valid,
	output logic [7:0]                   o_th_data,
	output logic                         o_th_last,
	output logic                         o_th_learn,
	// Host port to fabric, frame with tail tag and FCS
	input  wire logic                    i_fh_valid,
	input  wire logic [7:0]              i_fh_data,
	input  wire logic                    i_fh_last,
	input  wire logic [2:0]              i_fh_inst,
	output logic                         o_fh_ready,
	output logic                         o_fh_valid,
	output logic [7:0]                   o_fh_data,
	output logic                         o_fh_last,
	output logic [hpt_pkg::HPT_NPORT-1:0] o_fh_mask,
	output logic [1:0]                   o_fh_prio,
	output logic                         o_fh_lookup,
	// Host port status
	output logic                         o_tag_on,
	output logic [2:0]                   o_host_port
);
	import hpt_pkg::*;

	typedef enum {TH_DATA, TH_TAG, TH_FCS} hpt_th_t;
	typedef enum {FH_DATA, FH_FCS} hpt_fh_t;

	hpt_crc_if thc ();
	hpt_crc_if fhc ();
	logic [2:0]           ra_state, rb_state;
	logic [HPT_NPORT-1:0] txen;
	logic [2:0]           wp, wps, fh_vinst;

	// Register file state
	logic [HPT_NPORT-1:0] tte_reg, tte_next;
	logic [2:0]           ptr_reg [HPT_NPORT];
	logic [2:0]           ptr_next [HPT_NPORT];
	logic [31:0]          rdata_reg, rdata_next;
	logic                 on_reg, on_next, st_wr;
	logic [2:0]           host_reg, host_next;

	assign wp  = hpt_port_dec(i_addr);
	assign wps = (wp == HPT_PORT_NONE) ? 3'h0 : wp;

	// Register writes, reads, and host port selection
	always_comb begin
		tte_next   = tte_reg;
		ptr_next   = ptr_reg;
		rdata_next = 32'h00000000;
		st_wr      = 1'b0;
		if (i_wr && wp != HPT_PORT_NONE) begin
			case (i_addr[11:0])
				HPT_OFF_OPCTL: tte_next[wp] = i_wdata[HPT_TTE_BIT];
				HPT_OFF_MPTR:  ptr_next[wp] = i_wdata[2:0];
				HPT_OFF_MST:   st_wr = 1'b1;
				default:       ;
			endcase
		end
		if (i_rd && i_addr == HPT_OFF_STAT) begin
			rdata_next[HPT_STAT_ON] = on_reg;
			rdata_next[2:0]         = host_reg;
		end else if (i_rd && wp != HPT_PORT_NONE) begin
			case (i_addr[11:0])
				HPT_OFF_OPCTL: rdata_next[HPT_TTE_BIT] = tte_reg[wp];
				HPT_OFF_MPTR:  rdata_next[2:0] = ptr_reg[wp];
				HPT_OFF_MST:   rdata_next[2:0] = rb_state;
				default:       ;
			endcase
		end
		// Lowest enabled port wins if software enables more than one
		on_next   = |tte_next;
		host_next = 3'h0;
		for (int p = HPT_NPORT - 1; p >= 0; p--) begin
			if (tte_next[p])
				host_next = 3'(p);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			tte_reg   <= '0;
			ptr_reg   <= '{default: 3'h0};
			rdata_reg <= 32'h00000000;
			on_reg    <= 1'b0;
			host_reg  <= 3'h0;
		end else if (i_ce) begin
			tte_reg   <= tte_next;
			ptr_reg   <= ptr_next;
			rdata_reg <= rdata_next;
			on_reg    <= on_next;
			host_reg  <= host_next;
		end
	end

	assign o_rdata     = rdata_reg;
	assign o_tag_on    = on_reg;
	assign o_host_port = host_reg;

	hpt_stp u_stp (
		.i_clk      (i_clk),
		.i_reset    (i_reset),
		.i_ce       (i_ce),
		.i_wr       (st_wr),
		.i_wr_port  (wps),
		.i_wr_inst  (ptr_reg[wps]),
		.i_wr_state (i_wdata[2:0]),
		.i_ra_port  (i_th_src),
		.i_ra_inst  (i_th_inst),
		.o_ra_state (ra_state),
		.i_rb_port  (wps),
		.i_rb_inst  (ptr_reg[wps]),
		.o_rb_state (rb_state),
		.i_vec_inst (fh_vinst),
		.o_txen     (txen)
	);

	// To-host path state
	hpt_th_t    th_state, th_state_n;
	logic       th_first_reg, th_first_n, th_ok_reg, th_ok_n, th_ok_now;
	logic       th_tag_reg, th_tag_n, th_ptp_reg, th_ptp_n;
	logic       th_lrn_reg, th_lrn_n;
	logic [2:0] th_src_reg, th_src_n;
	logic [1:0] th_cnt_reg, th_cnt_n;
	logic       th_v_reg, th_v_n, th_l_reg, th_l_n, th_lo_reg, th_lo_n;
	logic [7:0] th_d_reg, th_d_n, th_tag_byte;

	assign th_ok_now   = th_first_reg ?
		hpt_host_ok(ra_state, i_th_ovr) : th_ok_reg;
	assign th_tag_byte = {th_ptp_reg, 4'h0, th_src_reg};

	// Forward, then tag byte, then fresh FCS
	always_comb begin
		th_state_n = th_state;
		th_first_n = th_first_reg;
		th_ok_n    = th_ok_reg;
		th_tag_n   = th_tag_reg;
		th_ptp_n   = th_ptp_reg;
		th_lrn_n   = th_lrn_reg;
		th_src_n   = th_src_reg;
		th_cnt_n   = th_cnt_reg;
		th_v_n     = 1'b0;
		th_d_n     = 8'h00;
		th_l_n     = 1'b0;
		th_lo_n    = 1'b0;
		thc.clr    = 1'b0;
		thc.en     = 1'b0;
		thc.dat    = i_th_data;
		case (th_state)
			TH_DATA: begin
				if (i_th_valid) begin
					if (th_first_reg) begin
						th_ok_n  = th_ok_now;
						th_tag_n = on_reg;
						th_ptp_n = i_th_ptp;
						th_src_n = i_th_src;
						th_lrn_n = !ra_state[HPT_ST_LDIS];
					end
					th_first_n = i_th_last;
					if (th_ok_now) begin
						th_v_n = 1'b1;
						th_d_n = i_th_data;
						thc.en = 1'b1;
					end
					if (i_th_last && th_ok_now)
						th_state_n = (th_first_reg ? on_reg : th_tag_reg) ?
							TH_TAG : TH_FCS;
					th_cnt_n = 2'h0;
				end
			end
			TH_TAG: begin
				th_v_n     = 1'b1;
				th_d_n     = th_tag_byte;
				thc.en     = 1'b1;
				thc.dat    = th_tag_byte;
				th_state_n = TH_FCS;
			end
			TH_FCS: begin
				th_v_n   = 1'b1;
				th_d_n   = hpt_byte_sel(thc.fcs, th_cnt_reg);
				th_cnt_n = th_cnt_reg + 2'h1;
				if (th_cnt_reg == HPT_FCS_LAST) begin
					th_l_n     = 1'b1;
					th_lo_n    = th_lrn_reg;
					thc.clr    = 1'b1;
					th_state_n = TH_DATA;
				end
			end
			default: th_state_n = TH_DATA;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			th_state <= TH_DATA;
			th_first_reg <= 1'b1;
			{th_ok_reg, th_tag_reg, th_ptp_reg, th_lrn_reg} <= 4'h0;
			th_src_reg <= 3'h0;
			th_cnt_reg <= 2'h0;
			{th_v_reg, th_l_reg, th_lo_reg} <= 3'h0;
			th_d_reg   <= 8'h00;
		end else if (i_ce) begin
			th_state <= th_state_n;
			th_first_reg <= th_first_n;
			{th_ok_reg, th_tag_reg, th_ptp_reg, th_lrn_reg} <=
				{th_ok_n, th_tag_n, th_ptp_n, th_lrn_n};
			th_src_reg <= th_src_n;
			th_cnt_reg <= th_cnt_n;
			{th_v_reg, th_l_reg, th_lo_reg} <= {th_v_n, th_l_n, th_lo_n};
			th_d_reg   <= th_d_n;
		end
	end

	assign thc.ce     = i_ce;
	assign o_th_ready = (th_state == TH_DATA);
	assign o_th_valid = th_v_reg;
	assign o_th_data  = th_d_reg;
	assign o_th_last  = th_l_reg;
	assign o_th_learn = th_lo_reg;

	hpt_crc u_th_crc (.i_clk(i_clk), .i_reset(i_reset), .bus(thc));

	// From-host path state; trailing bytes are held back until last
	hpt_fh_t    fh_state, fh_state_n;
	logic [7:0] fh_sr_reg [6];
	logic [7:0] fh_sr_n [6];
	logic       fh_first_reg, fh_first_n, fh_deep_reg, fh_deep_n, fh_dep;
	logic [2:0] fh_seen_reg, fh_seen_n, fh_cur, fh_inst_reg, fh_inst_n;
	logic [1:0] fh_cnt_reg, fh_cnt_n, fh_pr_reg, fh_pr_n;
	logic [HPT_NPORT-1:0] fh_m_reg, fh_m_n;
	logic       fh_lk_reg, fh_lk_n, fh_tagged;
	logic       fh_v_reg, fh_v_n, fh_l_reg, fh_l_n;
	logic [7:0] fh_d_reg, fh_d_n;
	logic [15:0] fh_tag;

	assign fh_dep   = fh_first_reg ? on_reg : fh_deep_reg;
	assign fh_cur   = fh_first_reg ? 3'h0 : fh_seen_reg;
	assign fh_vinst = fh_first_reg ? i_fh_inst : fh_inst_reg;
	assign fh_tag   = {fh_sr_reg[4], fh_sr_reg[3]};
	assign fh_tagged = (fh_state == FH_DATA) && i_fh_valid && i_fh_last &&
		fh_dep && fh_cur >= HPT_TAG_SEEN;

	always_comb begin
		fh_state_n = fh_state;
		fh_sr_n    = fh_sr_reg;
		fh_first_n = fh_first_reg;
		fh_deep_n  = fh_deep_reg;
		fh_seen_n  = fh_seen_reg;
		fh_inst_n  = fh_inst_reg;
		fh_cnt_n   = fh_cnt_reg;
		fh_m_n     = fh_m_reg;
		fh_pr_n    = fh_pr_reg;
		fh_lk_n    = fh_lk_reg;
		fh_v_n     = 1'b0;
		fh_d_n     = 8'h00;
		fh_l_n     = 1'b0;
		fhc.clr    = 1'b0;
		fhc.en     = 1'b0;
		fhc.dat    = fh_dep ? fh_sr_reg[5] : fh_sr_reg[3];
		case (fh_state)
			FH_DATA: begin
				if (i_fh_valid) begin
					fh_deep_n  = fh_dep;
					fh_inst_n  = fh_vinst;
					fh_first_n = i_fh_last;
					// Tag and old FCS never leave the block
					if (fh_cur >= (fh_dep ? HPT_HOLD_TAG : HPT_HOLD_FCS)) begin
						fh_v_n = 1'b1;
						fh_d_n = fhc.dat;
						fhc.en = 1'b1;
					end
					fh_sr_n[0] = i_fh_data;
					for (int i = 1; i < 6; i++)
						fh_sr_n[i] = fh_sr_reg[i-1];
					fh_seen_n = (fh_cur == HPT_HOLD_TAG) ? fh_cur : fh_cur + 3'h1;
					if (i_fh_last) begin
						fh_state_n = FH_FCS;
						fh_cnt_n   = 2'h0;
						fh_lk_n    = 1'b1;
						fh_m_n     = '0;
						fh_pr_n    = 2'h0;
						if (fh_tagged && !fh_tag[HPT_TT_LOOK]) begin
							fh_lk_n = 1'b0;
							fh_m_n  = fh_tag[HPT_NPORT-1:0] &
								(txen | {HPT_NPORT{fh_tag[HPT_TT_OVR]}});
							fh_pr_n = fh_tag[8:7];
						end
					end
				end
			end
			FH_FCS: begin
				fh_v_n   = 1'b1;
				fh_d_n   = hpt_byte_sel(fhc.fcs, fh_cnt_reg);
				fh_cnt_n = fh_cnt_reg + 2'h1;
				if (fh_cnt_reg == HPT_FCS_LAST) begin
					fh_l_n     = 1'b1;
					fhc.clr    = 1'b1;
					fh_state_n = FH_DATA;
				end
			end
			default: fh_state_n = FH_DATA;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			fh_state <= FH_DATA;
			fh_sr_reg <= '{default: 8'h00};
			fh_first_reg <= 1'b1;
			fh_deep_reg <= 1'b0;
			{fh_seen_reg, fh_inst_reg} <= 6'h00;
			{fh_cnt_reg, fh_pr_reg} <= 4'h0;
			fh_m_reg <= '0;
			{fh_lk_reg, fh_v_reg, fh_l_reg} <= 3'h0;
			fh_d_reg <= 8'h00;
		end else if (i_ce) begin
			fh_state <= fh_state_n;
			fh_sr_reg <= fh_sr_n;
			fh_first_reg <= fh_first_n;
			fh_deep_reg <= fh_deep_n;
			{fh_seen_reg, fh_inst_reg} <= {fh_seen_n, fh_inst_n};
			{fh_cnt_reg, fh_pr_reg} <= {fh_cnt_n, fh_pr_n};
			fh_m_reg <= fh_m_n;
			{fh_lk_reg, fh_v_reg, fh_l_reg} <= {fh_lk_n, fh_v_n, fh_l_n};
			fh_d_reg <= fh_d_n;
		end
	end

	assign fhc.ce      = i_ce;
	assign o_fh_ready  = (fh_state == FH_DATA);
	assign o_fh_valid  = fh_v_reg;
	assign o_fh_data   = fh_d_reg;
	assign o_fh_last   = fh_l_reg;
	assign o_fh_mask   = fh_m_reg;
	assign o_fh_prio   = fh_pr_reg;
	assign o_fh_lookup = fh_lk_reg;

	hpt_crc u_fh_crc (.i_clk(i_clk), .i_reset(i_reset), .bus(fhc));

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	chk_tag_reset_off: assert property (disable iff (1'b0)
		i_reset |=> !o_tag_on && !o_th_valid && !o_fh_valid)
		else $error("tagging active after reset");
	chk_th_tag_fmt: assert property ((i_ce && th_state == TH_TAG) |=>
		o_th_valid && o_th_data[2:0] == $past(th_src_reg) &&
		o_th_data[HPT_RT_PTP] == $past(th_ptp_reg) && o_th_data[6:3] == 4'h0)
		else $error("tag byte to host malformed");
	chk_th_host_only: assert property ((th_state == TH_TAG) |->
		th_tag_reg) else $error("tag inserted with tagging off");
	chk_th_tag_fcs: assert property ((i_ce && th_state == TH_TAG) |=>
		th_state == TH_FCS && th_cnt_reg == 2'h0)
		else $error("tag not directly before checksum");
	chk_th_discard: assert property ((i_ce && i_th_valid && th_first_reg &&
		th_state == TH_DATA && !hpt_host_ok(ra_state, i_th_ovr)) |=>
		!o_th_valid) else $error("discarding port frame reached host");
	chk_fh_lookup: assert property ((i_ce && fh_tagged &&
		fh_tag[HPT_TT_LOOK]) |=> o_fh_lookup && o_fh_mask == '0)
		else $error("lookup bit did not bypass tag");
	chk_fh_override: assert property ((i_ce && fh_tagged &&
		!fh_tag[HPT_TT_LOOK] && fh_tag[HPT_TT_OVR]) |=>
		!o_fh_lookup && o_fh_mask == $past(fh_tag[5:0]))
		else $error("blocking override ignored");
	chk_fh_prio: assert property ((i_ce && fh_tagged &&
		!fh_tag[HPT_TT_LOOK]) |=> o_fh_prio == $past(fh_tag[8:7]))
		else $error("egress queue not taken from tag");
	chk_fh_strip_end: assert property ((i_ce && fh_state == FH_FCS &&
		fh_cnt_reg == HPT_FCS_LAST) |=> o_fh_last && o_fh_valid &&
		o_fh_ready) else $error("host frame not closed by new checksum");
endmodule : hpt_top

// ==== tb/hpt_host_model.sv ====
`timescale 1ns/1ps
// Host MAC: sends frames with the two-byte tail tag and a valid FCS
module hpt_host_model (
	// Clock
	input  wire logic       i_clk,
	// Stream into the host port
	input  wire logic       i_ready,
	output logic            o_valid,
	output logic [7:0]      o_data,
	output logic            o_last
);
	import hpt_pkg::*;

	// Reflected CRC over a byte list, returned already inverted
	function automatic logic [31:0] crc(input logic [7:0] b[$]);
		logic [31:0] c;
		c = HPT_CRC_INIT;
		foreach (b[i]) begin
			c = c ^ {24'h0, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ HPT_CRC_POLY : c >> 1;
		end
		return ~c;
	endfunction : crc

	// Idle until the first frame
	initial begin
		o_valid = 1'b0;
		o_data  = 8'h0;
		o_last  = 1'b0;
	end

	// Payload, tag high, tag low, FCS low byte first; ok low on a stall
	task automatic send(input logic [7:0] p[$], input logic [15:0] t,
		output logic ok);
		logic [7:0]  f[$];
		logic [31:0] c;
		int          k;
		f = p;
		f.push_back(t[15:8]);
		f.push_back(t[7:0]);
		c = crc(f);
		for (int i = 0; i < 4; i++) f.push_back(c[8*i+:8]);
		ok = 1'b1;
		foreach (f[i]) begin
			o_valid <= 1'b1;
			o_data  <= f[i];
			o_last  <= (i == f.size() - 1);
			k = 0;
			do begin
				@(posedge i_clk);
				k++;
			end while (i_ready !== 1'b1 && k < 50);
			if (i_ready !== 1'b1) ok = 1'b0;
		end
		// Released data never keeps its last value
		o_valid <= 1'b0;
		o_data  <= ~o_data;
	endtask : send
endmodule : hpt_host_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	import hpt_pkg::*;
	logic        i_clk, i_reset, i_wr, i_rd, i_th_valid, i_th_last;
	logic        i_th_ptp, i_th_ovr, fh_valid, fh_last, tag_on;
	logic [15:0] i_addr;
	logic [31:0] i_wdata, o_rdata, seed;
	logic [7:0]  i_th_data, o_th_data, o_fh_data, fh_data;
	logic [2:0]  i_th_src, i_th_inst, i_fh_inst, o_host_port;
	logic        o_th_ready, o_th_valid, o_th_last, o_th_learn, o_tag_on;
	logic        o_fh_ready, o_fh_valid, o_fh_last, o_fh_lookup;
	logic [5:0]  o_fh_mask;
	logic [1:0]  o_fh_prio;
	logic [9:0]  qt[$];
	logic [8:0]  qf[$];
	int          mismatches, n_checks;

	hpt_top dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_th_valid(i_th_valid), .i_th_data(i_th_data),
		.i_th_last(i_th_last), .i_th_src(i_th_src),
		.i_th_inst(i_th_inst),
		.i_th_ptp(i_th_ptp), .i_th_ovr(i_th_ovr), .o_th_ready(o_th_ready),
		.o_th_valid(o_th_valid), .o_th_data(o_th_data),
		.o_th_last(o_th_last), .o_th_learn(o_th_learn),
		.i_fh_valid(fh_valid), .i_fh_data(fh_data), .i_fh_last(fh_last),
		.i_fh_inst(i_fh_inst), .o_fh_ready(o_fh_ready),
		.o_fh_valid(o_fh_valid), .o_fh_data(o_fh_data),
		.o_fh_last(o_fh_last), .o_fh_mask(o_fh_mask),
		.o_fh_prio(o_fh_prio), .o_fh_lookup(o_fh_lookup),
		.o_tag_on(o_tag_on), .o_host_port(o_host_port));
	hpt_host_model host_u (.i_clk(i_clk), .i_ready(o_fh_ready),
		.o_valid(fh_valid), .o_data(fh_data), .o_last(fh_last));

	// Clock
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	task automatic stop_test();
		if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd

	// Register bus: one-cycle strobes, read data in the next cycle only
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd   <= 1'b0;
		#1 chk(o_rdata, e);
	endtask : rd

	// Waits until every noted output has appeared
	task automatic drain();
		int k;
		k = 0;
		while ((qt.size() > 0 || qf.size() > 0) && k < 200) begin
			@(posedge i_clk);
			k++;
		end
		if (k >= 200) begin
			chk(0, 1);
			stop_test();
		end
	endtask : drain

	// Fabric frame to host; v: expected to pass, l: learning allowed
	task automatic th(input int n, input logic [2:0] s, input logic p,
		input logic o, input logic v, input logic l);
		logic [7:0]  f[$];
		logic [31:0] c;
		int          k;
		for (int i = 0; i < n; i++) f.push_back(rnd());
		if (v) foreach (f[i]) qt.push_back({2'b00, f[i]});
		if (v && tag_on) begin
			f.push_back({p, 4'h0, s});
			qt.push_back({2'b00, f[n]});
		end
		c = host_u.crc(f);
		for (int i = 0; i < 4 && v; i++)
			qt.push_back({l && i == 3, i == 3, c[8*i+:8]});
		@(posedge i_clk);
		for (int i = 0; i < n; i++) begin
			i_th_valid <= 1'b1;
			i_th_data  <= f[i];
			i_th_last  <= (i == n - 1);
			i_th_src   <= s;
			i_th_ptp   <= p;
			i_th_ovr   <= o;
			k = 0;
			do begin
				@(posedge i_clk);
				k++;
			end while (o_th_ready !== 1'b1 && k < 50);
			// A stalled port is a failure, never a silent stop
			if (o_th_ready !== 1'b1) begin
				chk(0, 1);
				stop_test();
			end
		end
		i_th_valid <= 1'b0;
		i_th_data  <= ~i_th_data;
	endtask : th

	// Host frame through the partner, then egress decision compared
	task automatic fh(input logic [15:0] t, input logic [2:0] inst,
		input logic [8:0] dec);
		logic [7:0]  p[$];
		logic [7:0]  e[$];
		logic [31:0] c;
		logic        ok;
		p = {8'h02, rnd()}; // Rapid tree version code leads
		e = p;
		if (!tag_on) e = {p, t[15:8], t[7:0]};
		c = host_u.crc(e);
		foreach (e[i]) qf.push_back({1'b0, e[i]});
		for (int i = 0; i < 4; i++) qf.push_back({i == 3, c[8*i+:8]});
		@(posedge i_clk);
		i_fh_inst <= inst;
		host_u.send(p, t, ok);
		if (!ok) begin
			chk(0, 1);
			stop_test();
		end
		drain();
		chk({o_fh_mask, o_fh_prio, o_fh_lookup}, dec);
	endtask : fh

	// Output watchers take the oldest note for each byte seen
	always @(posedge i_clk) if (o_th_valid === 1'b1) begin
		if (qt.size() == 0) chk(1, 0);
		else chk({o_th_learn & o_th_last, o_th_last, o_th_data},
			qt.pop_front());
	end
	always @(posedge i_clk) if (o_fh_valid === 1'b1) begin
		if (qf.size() == 0) chk(1, 0);
		else chk({o_fh_last, o_fh_data}, qf.pop_front());
	end

	// Main sequence
	initial begin
		{i_wr, i_rd, i_th_valid, i_th_last, i_th_ptp, i_th_ovr} = 6'h0;
		{i_addr, i_wdata, i_th_data, i_th_src, i_th_inst, i_fh_inst} = 'h0;
		{mismatches, n_checks, tag_on, seed} = {64'h0, 1'b0, 32'h49};
		i_reset = 1'b1;
		repeat (2) @(posedge i_clk);
		i_reset <= 1'b0;
		rd(16'h0000, 32'h0);
		th(3, 3'h2, 1'b0, 1'b0, 1'b1, 1'b1);
		fh(16'h0000, 3'h0, 9'h001);
		// Third port becomes the only host port
		wr(16'h3020, 32'h4);
		tag_on = 1'b1;
		rd(16'h0000, 32'h0000000a);
		chk({o_tag_on, o_host_port}, 4'ha);
		// Tree 0: first port discarding, second learning; tree 5 on port 4
		wr(16'h10b8, 32'h1);
		wr(16'h20b8, 32'h0);
		wr(16'h40b0, 32'h5);
		wr(16'h40b8, 32'h0);
		rd(16'h40b8, 32'h0);
		wr(16'h40b0, 32'h0);
		rd(16'h40b8, 32'h6);
		// Dropped, then let through by an override entry
		th(4, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
		th(4, 3'h0, 1'b0, 1'b1, 1'b1, 1'b0);
		th(3, 3'h1, 1'b1, 1'b0, 1'b1, 1'b1);
		th(2, 3'h5, 1'b1, 1'b0, 1'b1, 1'b1);
		// Same port in another tree instance forwards
		i_th_inst <= 3'h3;
		th(2, 3'h0, 1'b0, 1'b0, 1'b1, 1'b1);
		i_th_inst <= 3'h0;
		// Host frames: lookup, directed, override, other instance
		fh(16'h0400, 3'h0, 9'h001);
		fh(16'h010b, 3'h0, 9'h044);
		fh(16'h030b, 3'h0, 9'h05c);
		fh(16'h010b, 3'h3, 9'h05c);
		drain();
		stop_test();
	end
endmodule : testbench
